// [rtl/pff_pkg.sv]
// Package of register offsets, field positions and reset values for the fault flag bank
package pff_pkg;
  // Register offsets (printed offsets are not all multiples of four, so they are indices)
  localparam logic [7:0] TEMP_CRIT_IDX = 8'hb4;  // Critical temperature flags
  localparam logic [7:0] TEMP_HOT_IDX = 8'hb5;  // Hot temperature flags
  localparam logic [7:0] OVERCURRENT_IDX = 8'hb6;  // Low-side FET overcurrent flags
  localparam logic [7:0] RAIL_FAULT2_IDX = 8'hb3;  // Second rail-fault flags
  localparam logic [7:0] IRQ_MASK_IDX = 8'hc0;  // Interrupt mask, one bit per register
  // Byte addresses are four times the index
  localparam logic [11:0] TEMP_CRIT_ADDR = {2'h0, TEMP_CRIT_IDX, 2'h0};
  localparam logic [11:0] TEMP_HOT_ADDR = {2'h0, TEMP_HOT_IDX, 2'h0};
  localparam logic [11:0] OVERCURRENT_ADDR = {2'h0, OVERCURRENT_IDX, 2'h0};
  localparam logic [11:0] RAIL_FAULT2_ADDR = {2'h0, RAIL_FAULT2_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
  // Implemented bits per register
  localparam logic [7:0] TEMP_MASK = 8'h1f;  // Bits 4..0
  localparam logic [7:0] RAIL_MASK = 8'h1f;  // Bits 4..0
  localparam logic [7:0] OC_MASK = 8'h07;  // Bits 2..0
  localparam logic [3:0] IRQ_MASK_BITS = 4'hf;  // One enable per flag register
  // Field positions, temperature registers
  localparam int REST_OF_DIE_BIT = 4;
  localparam int TERM_LDO_TEMP_BIT = 3;
  localparam int UPPER_RIGHT_BIT = 2;
  localparam int UPPER_LEFT_BIT = 1;
  localparam int LOWER_RIGHT_BIT = 0;
  // Field positions, rail-fault register
  localparam int AUX_LDO_ONE_BIT = 4;
  localparam int TERM_LDO_RAIL_BIT = 3;
  localparam int LOAD_SW_B_TWO_BIT = 2;
  localparam int LOAD_SW_B_ONE_BIT = 1;
  localparam int AUX_LDO_THREE_BIT = 0;
  // Field positions, overcurrent register
  localparam int CTRL_SIX_OC_BIT = 2;
  localparam int CTRL_TWO_OC_BIT = 1;
  localparam int CTRL_ONE_OC_BIT = 0;
  // Reset values
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
endpackage

// [rtl/pff_fault_flags.sv]
// Sticky fault flag register bank with APB slave and interrupt output
//
// Overview of operation
// - Rail-fault register bits 4..0 map five rails
// - Rail flag sticks until host writes one
// - Critical-temperature flags register at index b4
// - Critical bits: die, term LDO, corners
// - Temperature and overcurrent flags clear by write-one
// - Hot-temperature flags register at index b5
// - Hot bits placed like critical bits
// - Overcurrent flags register at index b6
// - Overcurrent bits: controllers six, two, one
// - All flag registers reset to zero
//
// The APB register port was decided locally.
module pff_fault_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Critical temperature detectors
  input wire logic rest_of_die_critical,
  input wire logic termination_ldo_critical,
  input wire logic upper_right_critical,
  input wire logic upper_left_critical,
  input wire logic lower_right_critical,
  // Hot temperature detectors
  input wire logic rest_of_die_warm,
  input wire logic termination_ldo_warm,
  input wire logic upper_right_warm,
  input wire logic upper_left_warm,
  input wire logic lower_right_warm,
  // Low-side switch overcurrent detectors
  input wire logic controller_six_overcurrent,
  input wire logic controller_two_overcurrent,
  input wire logic controller_one_overcurrent,
  // Rail regulation-loss detectors
  input wire logic aux_ldo_one_fault,
  input wire logic termination_ldo_fault,
  input wire logic load_switch_b_two_fault,
  input wire logic load_switch_b_one_fault,
  input wire logic aux_ldo_three_fault
);

  // Flag registers and their next values
  logic [7:0] crit_r, crit_nxt;  // Critical temperature flags
  logic [7:0] hot_r, hot_nxt;  // Hot temperature flags
  logic [7:0] oc_r, oc_nxt;  // Overcurrent flags
  logic [7:0] rail_r, rail_nxt;  // Second rail-fault flags
  logic [3:0] mask_r;  // Interrupt enables: bit0 crit, 1 hot, 2 oc, 3 rail
  logic [7:0] crit_set, hot_set, oc_set, rail_set;  // Detector vectors
  logic [7:0] crit_clr, hot_clr, oc_clr, rail_clr;  // Write-one-clear vectors
  logic wr_acc;  // Write access phase
  logic rd_acc;  // Read access phase
  logic addr_ok;  // Address hits a mapped register
  logic [31:0] rd_mux;  // Read data selected by address
  logic [3:0] pend;  // Per-register pending summary

  // Gather detector inputs into register layouts
  always_comb begin
    crit_set = 8'h00;
    crit_set[pff_pkg::REST_OF_DIE_BIT] = rest_of_die_critical;
    crit_set[pff_pkg::TERM_LDO_TEMP_BIT] = termination_ldo_critical;
    crit_set[pff_pkg::UPPER_RIGHT_BIT] = upper_right_critical;
    crit_set[pff_pkg::UPPER_LEFT_BIT] = upper_left_critical;
    crit_set[pff_pkg::LOWER_RIGHT_BIT] = lower_right_critical;
    hot_set = 8'h00;
    hot_set[pff_pkg::REST_OF_DIE_BIT] = rest_of_die_warm;
    hot_set[pff_pkg::TERM_LDO_TEMP_BIT] = termination_ldo_warm;
    hot_set[pff_pkg::UPPER_RIGHT_BIT] = upper_right_warm;
    hot_set[pff_pkg::UPPER_LEFT_BIT] = upper_left_warm;
    hot_set[pff_pkg::LOWER_RIGHT_BIT] = lower_right_warm;
    oc_set = 8'h00;
    oc_set[pff_pkg::CTRL_SIX_OC_BIT] = controller_six_overcurrent;
    oc_set[pff_pkg::CTRL_TWO_OC_BIT] = controller_two_overcurrent;
    oc_set[pff_pkg::CTRL_ONE_OC_BIT] = controller_one_overcurrent;
    rail_set = 8'h00;
    rail_set[pff_pkg::AUX_LDO_ONE_BIT] = aux_ldo_one_fault;
    rail_set[pff_pkg::TERM_LDO_RAIL_BIT] = termination_ldo_fault;
    rail_set[pff_pkg::LOAD_SW_B_TWO_BIT] = load_switch_b_two_fault;
    rail_set[pff_pkg::LOAD_SW_B_ONE_BIT] = load_switch_b_one_fault;
    rail_set[pff_pkg::AUX_LDO_THREE_BIT] = aux_ldo_three_fault;
  end

  // Access phase qualifiers; slave always answers in the first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // Address decode for the mapped registers
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == pff_pkg::TEMP_CRIT_ADDR) begin
      rd_mux = {24'h00_0000, crit_r};
    end else if (paddr == pff_pkg::TEMP_HOT_ADDR) begin
      rd_mux = {24'h00_0000, hot_r};
    end else if (paddr == pff_pkg::OVERCURRENT_ADDR) begin
      rd_mux = {24'h00_0000, oc_r};
    end else if (paddr == pff_pkg::RAIL_FAULT2_ADDR) begin
      rd_mux = {24'h00_0000, rail_r};
    end else if (paddr == pff_pkg::IRQ_MASK_ADDR) begin
      rd_mux = {28'h000_0000, mask_r};
    end else begin
      addr_ok = 1'b0;  // Unmapped: error answer, data zero
    end
  end

  // Clear vectors: only ones written through the low byte lane clear
  always_comb begin
    crit_clr = 8'h00;
    hot_clr = 8'h00;
    oc_clr = 8'h00;
    rail_clr = 8'h00;
    if (wr_acc && pstrb[0]) begin
      if (paddr == pff_pkg::TEMP_CRIT_ADDR) begin
        crit_clr = pwdata[7:0];
      end else if (paddr == pff_pkg::TEMP_HOT_ADDR) begin
        hot_clr = pwdata[7:0];
      end else if (paddr == pff_pkg::OVERCURRENT_ADDR) begin
        oc_clr = pwdata[7:0];
      end else if (paddr == pff_pkg::RAIL_FAULT2_ADDR) begin
        rail_clr = pwdata[7:0];
      end
    end
  end

  // Next values: set wins over clear, zero written keeps, reserved forced zero
  always_comb begin
    crit_nxt = ((crit_r & ~crit_clr) | crit_set) & pff_pkg::TEMP_MASK;
    hot_nxt = ((hot_r & ~hot_clr) | hot_set) & pff_pkg::TEMP_MASK;
    oc_nxt = ((oc_r & ~oc_clr) | oc_set) & pff_pkg::OC_MASK;
    rail_nxt = ((rail_r & ~rail_clr) | rail_set) & pff_pkg::RAIL_MASK;
  end

  // Sticky flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crit_r <= pff_pkg::FLAG_RESET;
      hot_r <= pff_pkg::FLAG_RESET;
      oc_r <= pff_pkg::FLAG_RESET;
      rail_r <= pff_pkg::FLAG_RESET;
    end else begin
      crit_r <= crit_nxt;
      hot_r <= hot_nxt;
      oc_r <= oc_nxt;
      rail_r <= rail_nxt;
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= pff_pkg::IRQ_MASK_RESET;
    end else if (wr_acc && pstrb[0] && paddr == pff_pkg::IRQ_MASK_ADDR) begin
      mask_r <= pwdata[3:0] & pff_pkg::IRQ_MASK_BITS;
    end
  end

  // APB answer registers: pready is a one-cycle pulse in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Per-register pending from the next flag state so irq tracks flags exactly
  assign pend = {|rail_nxt, |oc_nxt, |hot_nxt, |crit_nxt};

  // Level interrupt, high while any enabled register holds a flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(pend & mask_r);
    end
  end

  // Assertions

  // Read and setup cycles used by the bus properties
  sequence crit_rd_s;
    psel && !penable && !pwrite && paddr == pff_pkg::TEMP_CRIT_ADDR;
  endsequence

  sequence rail_rd_s;
    psel && !penable && !pwrite && paddr == pff_pkg::RAIL_FAULT2_ADDR;
  endsequence

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  // A critical flag that was set and not cleared is still set one edge later
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (($past(crit_r) & ~$past(crit_clr)) & ~crit_r) == 8'h00)
    else $error("critical flag lost without clear");

  crit_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    rest_of_die_critical |=> crit_r[pff_pkg::REST_OF_DIE_BIT])
    else $error("critical die flag not captured");

  hot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    hot_r[pff_pkg::TERM_LDO_TEMP_BIT] && !hot_clr[pff_pkg::TERM_LDO_TEMP_BIT]
    |=> hot_r[pff_pkg::TERM_LDO_TEMP_BIT])
    else $error("hot flag dropped without clear");

  oc_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    controller_six_overcurrent |=> oc_r[pff_pkg::CTRL_SIX_OC_BIT])
    else $error("controller six overcurrent not captured");

  rail_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rail_clr[pff_pkg::AUX_LDO_ONE_BIT] && !aux_ldo_one_fault
    |=> !rail_r[pff_pkg::AUX_LDO_ONE_BIT])
    else $error("rail flag not cleared by write one");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    oc_clr[pff_pkg::CTRL_ONE_OC_BIT] && controller_one_overcurrent
    |=> oc_r[pff_pkg::CTRL_ONE_OC_BIT])
    else $error("clear beat an active detector");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (crit_r[7:5] == 3'h0) && (hot_r[7:5] == 3'h0) && (oc_r[7:3] == 5'h00)
    && (rail_r[7:5] == 3'h0))
    else $error("reserved flag bit set");

  rail_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_switch_b_two_fault |=> rail_r[pff_pkg::LOAD_SW_B_TWO_BIT])
    else $error("rail switch b two flag not captured");

  hot_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    lower_right_warm |=> hot_r[pff_pkg::LOWER_RIGHT_BIT])
    else $error("hot lower right flag not captured");

  crit_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    upper_left_critical |=> crit_r[pff_pkg::UPPER_LEFT_BIT])
    else $error("critical upper left flag not captured");

  oc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == pff_pkg::OVERCURRENT_ADDR
    |=> pready && prdata == {24'h00_0000, $past(oc_r, 1)})
    else $error("overcurrent read data wrong");

  hot_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == pff_pkg::TEMP_HOT_ADDR
    |=> prdata == {24'h00_0000, $past(hot_r, 1)})
    else $error("hot read data wrong");

  // Mapped critical read: ready without error, data from the setup cycle
  crit_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    crit_rd_s |=> pready && !pslverr && prdata == {24'h00_0000, $past(crit_r, 1)})
    else $error("critical read data wrong");

  // Mapped rail-fault read returns the flags of the setup cycle
  rail_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rail_rd_s |=> pready && !pslverr && prdata == {24'h00_0000, $past(rail_r, 1)})
    else $error("rail read data wrong");

  // Every setup cycle gets its answer in the first access cycle
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> pready)
    else $error("setup cycle not answered");

  // Ready stands for one cycle only
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for two cycles");

  // Addresses below the register window answer with an error
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s ##0 paddr[11:8] == 4'h0 |=> pslverr)
    else $error("unmapped access without error");

  // A write with the low lane disabled leaves the flags alone
  strobe_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && !pstrb[0] && paddr == pff_pkg::TEMP_CRIT_ADDR && crit_set == 8'h00
    |=> crit_r == $past(crit_r, 1))
    else $error("flags changed by a disabled byte lane");

  // Zeros written to the hot register keep every flag
  zero_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && pstrb[0] && paddr == pff_pkg::TEMP_HOT_ADDR && pwdata[7:0] == 8'h00
    |=> (hot_r & $past(hot_r, 1)) == $past(hot_r, 1))
    else $error("hot flag lost on a zero write");

  // Write one clears a controller two flag when its detector is quiet
  oc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    oc_clr[pff_pkg::CTRL_TWO_OC_BIT] && !controller_two_overcurrent
    |=> !oc_r[pff_pkg::CTRL_TWO_OC_BIT])
    else $error("overcurrent flag not cleared by write one");

  // No interrupt while every register is masked
  irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_r == 4'h0 |=> !irq)
    else $error("interrupt raised while masked");

  // An enabled critical detector raises the interrupt at the next edge
  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_r[0] && rest_of_die_critical |=> irq)
    else $error("enabled critical flag without interrupt");

  // Everything is quiet at the first edge after reset
  reset_zero_a: assert property (@(posedge pclk)
    $rose(presetn) |-> crit_r == 8'h00 && hot_r == 8'h00 && oc_r == 8'h00
    && rail_r == 8'h00 && mask_r == 4'h0 && !irq)
    else $error("flags not zero after reset");

endmodule

// [verif/pff_detector_model.sv]
// Detector model: drives the fault detector lines from one request vector
module pff_detector_model (
  input wire logic [17:0] raise,
  output logic [4:0] crit,
  output logic [4:0] hot,
  output logic [2:0] oc,
  output logic [4:0] rail
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level detectors: a request bit stands as long as the condition lasts
  assign {rail, oc, hot, crit} = raise;
endmodule

// [verif/pff_fault_flags_test.sv]
// Self-checking bench for the sticky fault flag bank
module pff_fault_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, irq, er;
  logic [17:0] raise = '0;  // Detector requests: crit, hot, oc, rail from bit 0
  logic [4:0] crit, hot, rail;
  logic [2:0] oc;
  int fails = 0, samples_checked = 0;
  // Flag registers and where their bits sit in the request vector
  logic [11:0] ra [4] = '{pff_pkg::TEMP_CRIT_ADDR, pff_pkg::TEMP_HOT_ADDR,
    pff_pkg::OVERCURRENT_ADDR, pff_pkg::RAIL_FAULT2_ADDR};
  int lo [4] = '{0, 5, 10, 13};
  logic [7:0] rm [4] = '{8'h1f, 8'h1f, 8'h07, 8'h1f};
  pff_detector_model pff_detector_model_inst (.raise(raise), .crit(crit), .hot(hot),
    .oc(oc), .rail(rail));
  pff_fault_flags pff_fault_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .rest_of_die_critical(crit[4]), .termination_ldo_critical(crit[3]),
    .upper_right_critical(crit[2]), .upper_left_critical(crit[1]),
    .lower_right_critical(crit[0]), .rest_of_die_warm(hot[4]),
    .termination_ldo_warm(hot[3]), .upper_right_warm(hot[2]), .upper_left_warm(hot[1]),
    .lower_right_warm(hot[0]), .controller_six_overcurrent(oc[2]),
    .controller_two_overcurrent(oc[1]), .controller_one_overcurrent(oc[0]),
    .aux_ldo_one_fault(rail[4]), .termination_ldo_fault(rail[3]),
    .load_switch_b_two_fault(rail[2]), .load_switch_b_one_fault(rail[1]),
    .aux_ldo_three_fault(rail[0]));
  // Free-running 20 MHz clock
  initial forever #25 pclk = ~pclk;
  // Prints the counts and the verdict, then ends the run
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compares one value and counts it
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // One APB transfer; entered right after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, data and error are taken at the rising edge that samples ready high
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        got = 1;
        rd = prdata;
        er = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!got) begin
      fails++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  // Looks at the interrupt line mid-cycle, then returns right after a rising edge
  task automatic chk_irq(input string n, input logic e);
    @(negedge pclk);
    chk(n, 32'(e), 32'(irq));
    @(posedge pclk);
  endtask
  // Reads all four flag registers against the expected request pattern
  task automatic chk_all(input logic [17:0] v);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ra[k], '0);
      chk("flags", 32'((v >> lo[k]) & rm[k]), rd);
    end
  endtask
  // One-cycle detector pulse
  task automatic pulse(input logic [17:0] v);
    raise <= v;
    @(posedge pclk);
    raise <= '0;
    @(posedge pclk);
  endtask
  // Write-one to every bit, reserved ones included
  task automatic clear_all;
    for (int k = 0; k < 4; k++) apb(1'b1, ra[k], 32'hff);
  endtask
  task automatic t_reset;
    chk_all('0);
    apb(1'b0, pff_pkg::IRQ_MASK_ADDR, '0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 12'h004, '0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hff);
    chk("unmapped write err", 32'h1, 32'(er));
    $display("test reset done");
  endtask
  task automatic t_map;
    for (int i = 0; i < 18; i++) begin
      pulse(18'h1 << i);
      chk_all(18'h1 << i);
      clear_all();
    end
    chk_all('0);
    $display("test map done");
  endtask
  task automatic t_keep;
    pulse('1);
    for (int k = 0; k < 4; k++) apb(1'b1, ra[k], 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, ra[0], 32'hff);
    pstrb <= 4'h1;
    chk_all('1);
    for (int k = 0; k < 4; k++) apb(1'b1, ra[k], 32'h1);
    chk_all(18'h3dbde);
    clear_all();
    chk_all('0);
    $display("test keep done");
  endtask
  task automatic t_hold;
    raise <= 18'h401;
    @(posedge pclk);
    apb(1'b1, ra[0], 32'h1f);
    apb(1'b1, ra[2], 32'h7);
    raise <= '0;
    @(posedge pclk);
    chk_all(18'h401);
    clear_all();
    chk_all('0);
    $display("test hold done");
  endtask
  task automatic t_irq;
    pulse(18'h20);
    chk_irq("irq masked", 1'b0);
    apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'hff);
    apb(1'b0, pff_pkg::IRQ_MASK_ADDR, '0);
    chk("mask", 32'hf, rd);
    chk_irq("irq on", 1'b1);
    apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'hd);
    chk_irq("irq off", 1'b0);
    apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'h2);
    chk_irq("irq hot", 1'b1);
    apb(1'b1, ra[1], 32'h1);
    chk_irq("irq cleared", 1'b0);
    // Each mask bit enables its own register and no other
    for (int k = 0; k < 4; k++) begin
      pulse(18'h1 << lo[k]);
      apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'(4'hf & ~(4'h1 << k)));
      chk_irq("irq other", 1'b0);
      apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'(4'h1 << k));
      chk_irq("irq own", 1'b1);
      clear_all();
      chk_irq("irq own cleared", 1'b0);
    end
    $display("test irq done");
  endtask
  // Reset in mid-run with flags and mask set
  task automatic t_rst_mid;
    apb(1'b1, pff_pkg::IRQ_MASK_ADDR, 32'hf);
    pulse('1);
    chk_irq("irq before reset", 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_all('0);
    apb(1'b0, pff_pkg::IRQ_MASK_ADDR, '0);
    chk("mask after reset", 32'h0, rd);
    chk_irq("irq after reset", 1'b0);
    $display("test mid reset done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_map();
    t_keep();
    t_hold();
    t_irq();
    t_rst_mid();
    tally_and_finish();
  end
endmodule
